// File: rtl/rfa_pkg.sv
// Package of field classes, widths and reset constants for the field access register
package rfa_pkg;

	// Register geometry
	localparam int unsigned REG_WIDTH = 32;

	// Per-bit access class codes (two bits per register bit)
	typedef enum logic [1:0] {
		RFA_CLASS_RW,
		RFA_CLASS_RO,
		RFA_CLASS_RSVD,
		RFA_CLASS_CLR
	} rfa_class_e;

	// Default class map: bits 7:0 read-write, 15:8 read-only, 23:16 reserved,
	// 24 software-clear-only, 31:25 reserved
	localparam logic [2*REG_WIDTH-1:0] CLASS_MAP_DEF = {
		{7{2'h2}}, 2'h3, {8{2'h2}}, {8{2'h1}}, {8{2'h0}}
	};

	// Read-only bits taken from configuration pins at reset ("externally set")
	localparam logic [REG_WIDTH-1:0] EXT_SET_MASK_DEF  = 32'h0000_F000;
	// Preset value for read-only bits not externally set
	localparam logic [REG_WIDTH-1:0] PRESET_VALUE_DEF  = 32'h0000_0000;
	// Reset value for read-write bits
	localparam logic [REG_WIDTH-1:0] RW_RESET_DEF      = 32'h0000_0000;
	// Read-only bits whose reset state is undefined (reset to the preset value but not flagged known)
	localparam logic [REG_WIDTH-1:0] UNDEF_MASK_DEF    = 32'h0000_0000;

	// All-zero word
	localparam logic [REG_WIDTH-1:0] ZERO_WORD = 32'h0000_0000;

endpackage

// File: rtl/rfa_class_decode.sv
// Per-bit decode of access class codes into write-path masks
`timescale 1ns/1ps
module rfa_class_decode
	import rfa_pkg::*;
#(
	parameter int unsigned WIDTH = REG_WIDTH
)(
	// Class map input
	input  wire logic [2*WIDTH-1:0] class_map_in,
	// Decoded masks
	output logic      [WIDTH-1:0]   rw_mask_out,
	output logic      [WIDTH-1:0]   ro_mask_out,
	output logic      [WIDTH-1:0]   rsvd_mask_out,
	output logic      [WIDTH-1:0]   clr_mask_out
);

	// One decoder per bit so every field gets its class behaviour in parallel
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign rw_mask_out[i]  = (class_map_in[2*i +: 2] == RFA_CLASS_RW);
		assign ro_mask_out[i]  = (class_map_in[2*i +: 2] == RFA_CLASS_RO);
		assign rsvd_mask_out[i] = (class_map_in[2*i +: 2] == RFA_CLASS_RSVD);
		assign clr_mask_out[i]  = (class_map_in[2*i +: 2] == RFA_CLASS_CLR);
	end

endmodule // rfa_class_decode

// File: rtl/rfa_strap_capture.sv
// Captures external configuration straps after reset release
`timescale 1ns/1ps
module rfa_strap_capture
	import rfa_pkg::*;
#(
	parameter int unsigned WIDTH = REG_WIDTH
)(
	// Clock and reset
	input  wire logic             clock_in,
	input  wire logic             rst_n_in,
	// Strap pins
	input  wire logic [WIDTH-1:0] strap_in,
	// Captured value and done flag
	output logic      [WIDTH-1:0] strap_out,
	output logic                  strap_valid_out
);

	typedef struct packed {
		logic [WIDTH-1:0] sync1;
		logic [WIDTH-1:0] sync2;
		logic [WIDTH-1:0] value;
		logic [1:0]       cnt;
		logic             valid;
	} rfa_strap_s;

	rfa_strap_s st_q;
	rfa_strap_s st_d;

	// Pins are asynchronous: two flops, then wait for the sync to fill before latching
	always_comb
	begin
		st_d       = st_q;
		st_d.sync1 = strap_in;
		st_d.sync2 = st_q.sync1;
		if (!st_q.valid)
		begin
			if (st_q.cnt == 2'h2)
			begin
				st_d.value = st_q.sync2;
				st_d.valid = 1'b1;
			end
			else
			begin
				st_d.cnt = st_q.cnt + 2'h1;
			end
		end
	end

	// Synchronous reset takes constants only
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign strap_out       = st_q.value;
	assign strap_valid_out = st_q.valid;

endmodule // rfa_strap_capture

// File: rtl/rfa_field_reg.sv
// Control register whose fields obey per-bit access classes
`timescale 1ns/1ps
// What this block does
// - Read-write bits are readable and writable by software and hardware.
// - Hardware updates to read-write bits show on the next read.
// - Software writes to read-write bits show on every later read.
// - Read-only bits are constant or changed by hardware only.
// - Read-only bits reset to zero, preset or external value at power-up.
// - Externally set read-only bits load from configuration pins.
// - Undefined-reset read-only bits change only on their defined hardware update.
// - Software writes to read-only bits are discarded entirely.
// - Reads of read-only bits return the last hardware value.
// - Undefined-reset read-only bits may read unpredictable until first update.
// - Software writes to reserved bits are discarded with no effect.
// - Reserved bits always read as zero.
// - Reserved bits reset to zero.
// - A register write drops reserved parts but updates writable fields.
// - Clear-only bits ignore software ones; hardware may set or clear.
module rfa_field_reg
	import rfa_pkg::*;
#(
	parameter int unsigned           WIDTH        = REG_WIDTH,
	parameter logic [2*WIDTH-1:0]    CLASS_MAP    = CLASS_MAP_DEF,
	parameter logic [WIDTH-1:0]      EXT_SET_MASK = EXT_SET_MASK_DEF,
	parameter logic [WIDTH-1:0]      PRESET_VALUE = PRESET_VALUE_DEF,
	parameter logic [WIDTH-1:0]      RW_RESET     = RW_RESET_DEF,
	parameter logic [WIDTH-1:0]      UNDEF_MASK   = UNDEF_MASK_DEF
)(
	// Clock and reset
	input  wire logic             clock_in,
	input  wire logic             rst_n_in,
	// Software access (coprocessor register write and read)
	input  wire logic             sw_wr_in,
	input  wire logic [WIDTH-1:0] sw_wdata_in,
	input  wire logic             sw_rd_in,
	output logic      [WIDTH-1:0] sw_rdata_out,
	output logic                  sw_rvalid_out,
	// Hardware update port
	input  wire logic             hw_wr_in,
	input  wire logic [WIDTH-1:0] hw_wmask_in,
	input  wire logic [WIDTH-1:0] hw_wdata_in,
	// Configuration straps
	input  wire logic [WIDTH-1:0] strap_in,
	// Hardware view of the register
	output logic      [WIDTH-1:0] hw_value_out,
	output logic                  cfg_ready_out,
	output logic      [WIDTH-1:0] ro_known_out
);

	import rfa_pkg::*;

	// Decoded per-bit masks
	logic [WIDTH-1:0] rw_mask;
	logic [WIDTH-1:0] ro_mask;
	logic [WIDTH-1:0] rsvd_mask;
	logic [WIDTH-1:0] clr_mask;
	logic [WIDTH-1:0] strap_val;
	logic             strap_valid;

	rfa_class_decode #(
		.WIDTH (WIDTH)
	) u_decode (
		.class_map_in (CLASS_MAP),
		.rw_mask_out  (rw_mask),
		.ro_mask_out  (ro_mask),
		.rsvd_mask_out (rsvd_mask),
		.clr_mask_out  (clr_mask)
	);

	rfa_strap_capture #(
		.WIDTH (WIDTH)
	) u_strap (
		.clock_in        (clock_in),
		.rst_n_in        (rst_n_in),
		.strap_in        (strap_in),
		.strap_out       (strap_val),
		.strap_valid_out (strap_valid)
	);

	typedef struct packed {
		logic [WIDTH-1:0] value;
		logic [WIDTH-1:0] known;
		logic [WIDTH-1:0] rdata;
		logic             rvalid;
		logic             loaded;
		logic [WIDTH-1:0] hw_view;
	} rfa_state_s;

	rfa_state_s st_q;
	rfa_state_s st_d;

	// Masks gathered once so each bit's write rule is a simple select
	logic [WIDTH-1:0] sw_mask;
	logic [WIDTH-1:0] hw_mask;
	logic [WIDTH-1:0] ext_mask;

	always_comb
	begin
		// Software reaches read-write bits fully, clear-only bits only where it writes zero
		sw_mask = sw_wr_in ? (rw_mask | (clr_mask & ~sw_wdata_in)) : ZERO_WORD;
		// Hardware reaches every bit except reserved ones
		hw_mask = hw_wr_in ? (hw_wmask_in & ~rsvd_mask) : ZERO_WORD;
		// Strap-loaded read-only bits; the load below waits for the synchroniser to settle
		ext_mask = EXT_SET_MASK & ro_mask;
	end

	// Next-state logic: software first, hardware update wins on the same bit
	always_comb
	begin
		st_d = st_q;
		// Read-write bits take software data; clear-only bits take only zero
		st_d.value = (st_q.value & ~sw_mask) | (sw_wdata_in & sw_mask & rw_mask);
		// Read-only and reserved bits never see software data
		st_d.value = st_d.value & ~(sw_mask & (ro_mask | rsvd_mask));
		// One-shot strap load sits below hardware so a same-cycle update is not overwritten
		if (!st_q.loaded && strap_valid)
		begin
			st_d.value  = (st_d.value & ~ext_mask) | (strap_val & ext_mask);
			st_d.known  = st_d.known | ext_mask;
			st_d.loaded = 1'b1;
		end
		// Hardware has priority so a same-cycle event is not lost
		st_d.value = (st_d.value & ~hw_mask) | (hw_wdata_in & hw_mask);
		st_d.known = st_d.known | hw_mask;
		// Reserved bits are forced to zero whatever happens
		st_d.value = st_d.value & ~rsvd_mask;
		// Reads: reserved bits return zero, others the stored value
		st_d.rvalid = sw_rd_in;
		if (sw_rd_in)
			st_d.rdata = st_q.value & ~rsvd_mask;
		st_d.hw_view = st_d.value;
	end

	// Reset: read-write and read-only bits to their preset pattern, reserved to zero
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			st_q.value   <= ((RW_RESET & rw_mask) | (PRESET_VALUE & ro_mask)) & ~rsvd_mask;
			st_q.known   <= ~(UNDEF_MASK & ro_mask) & ~EXT_SET_MASK;
			st_q.rdata   <= ZERO_WORD;
			st_q.rvalid  <= 1'b0;
			st_q.loaded  <= 1'b0;
			st_q.hw_view <= ZERO_WORD;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from flops; reads return the last hardware value for read-only bits
	assign sw_rdata_out  = st_q.rdata;
	assign sw_rvalid_out = st_q.rvalid;
	assign hw_value_out  = st_q.hw_view;
	assign cfg_ready_out = st_q.loaded;
	assign ro_known_out  = st_q.known;

endmodule // rfa_field_reg

// File: tb/rfa_field_reg_props.sv
// Checker of field access behaviour at the register ports
`timescale 1ns/1ps
module rfa_field_reg_props #(
	parameter int unsigned WIDTH = 32
)(
	// Clock and reset
	input wire logic             clock_in,
	input wire logic             rst_n_in,
	// Software and hardware access
	input wire logic             sw_wr_in,
	input wire logic [WIDTH-1:0] sw_wdata_in,
	input wire logic             sw_rd_in,
	input wire logic [WIDTH-1:0] sw_rdata_out,
	input wire logic             sw_rvalid_out,
	input wire logic             hw_wr_in,
	input wire logic [WIDTH-1:0] hw_wmask_in,
	input wire logic [WIDTH-1:0] hw_wdata_in,
	input wire logic [WIDTH-1:0] strap_in,
	input wire logic [WIDTH-1:0] hw_value_out,
	input wire logic             cfg_ready_out,
	input wire logic [WIDTH-1:0] ro_known_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	// Software write with no hardware update in the same cycle, so the outcome is software's
	sequence s_sw_only;
		sw_wr_in && !hw_wr_in;
	endsequence
	// Stored value reaches hw_value_out at the sampling edge after the write edge
	chk_rsvd_read_zero: assert property (sw_rvalid_out |-> (sw_rdata_out & 32'hFEFF_0000) == 0)
		else $error("reserved bits read nonzero");
	chk_rsvd_hold_zero: assert property ((hw_value_out & 32'hFEFF_0000) == 0)
		else $error("reserved bits hold nonzero");
	// A read returns the content held at the edge that took it
	chk_read_returns: assert property (sw_rd_in |=>
		sw_rvalid_out && sw_rdata_out == $past(hw_value_out))
		else $error("read answer wrong");
	chk_rvalid_cause: assert property (sw_rvalid_out |-> $past(sw_rd_in))
		else $error("read valid without read");
	chk_ro_sw_ignored: assert property (cfg_ready_out ##0 s_sw_only |=>
		hw_value_out[15:8] == $past(hw_value_out[15:8]))
		else $error("software changed read-only bits");
	chk_rw_sw_write: assert property (s_sw_only |=>
		hw_value_out[7:0] == $past(sw_wdata_in[7:0]))
		else $error("read-write bits not written");
	chk_hw_update: assert property (hw_wr_in |=>
		((hw_value_out ^ $past(hw_wdata_in)) & $past(hw_wmask_in) & 32'h0100_FFFF) == 0)
		else $error("hardware update lost");
	chk_clear_only_keep: assert property (s_sw_only ##0 sw_wdata_in[24] |=>
		hw_value_out[24] == $past(hw_value_out[24]))
		else $error("clear-only bit changed by a one");
	chk_ready_holds: assert property (cfg_ready_out |=> cfg_ready_out)
		else $error("strap ready dropped");
endmodule // rfa_field_reg_props
bind rfa_field_reg rfa_field_reg_props #(.WIDTH(WIDTH)) u_props (.clock_in(clock_in), .rst_n_in(rst_n_in),
	.sw_wr_in(sw_wr_in), .sw_wdata_in(sw_wdata_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
	.sw_rvalid_out(sw_rvalid_out), .hw_wr_in(hw_wr_in), .hw_wmask_in(hw_wmask_in),
	.hw_wdata_in(hw_wdata_in), .strap_in(strap_in), .hw_value_out(hw_value_out),
	.cfg_ready_out(cfg_ready_out), .ro_known_out(ro_known_out));

// File: tb/rfa_field_reg_tb.sv
// Self-checking bench for the field access register
`timescale 1ns/1ps
module rfa_field_reg_tb;
	import rfa_pkg::*;
	localparam logic [31:0] RW_M = 32'h0000_00FF;
	localparam logic [31:0] CO_M = 32'h0100_0000;
	localparam logic [31:0] RS_M = 32'hFEFF_0000;
	logic        clock_in = 1'b0, rst_n_in = 1'b0, sw_wr_in = 1'b0, sw_rd_in = 1'b0, hw_wr_in = 1'b0;
	logic [31:0] sw_wdata_in = 32'h0, hw_wmask_in = 32'h0, hw_wdata_in = 32'h0;
	logic [31:0] strap_in = 32'h0000_A5A5;
	logic [31:0] sw_rdata_out, hw_value_out, ro_known_out, exp_q, a, b;
	logic [31:0] rnd = 32'h0000_004E;
	logic        sw_rvalid_out, cfg_ready_out;
	int          failures = 0, samples_checked = 0, cycles = 0;
	rfa_field_reg uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .sw_wr_in(sw_wr_in),
		.sw_wdata_in(sw_wdata_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
		.sw_rvalid_out(sw_rvalid_out), .hw_wr_in(hw_wr_in), .hw_wmask_in(hw_wmask_in),
		.hw_wdata_in(hw_wdata_in), .strap_in(strap_in), .hw_value_out(hw_value_out),
		.cfg_ready_out(cfg_ready_out), .ro_known_out(ro_known_out));
	// 10 MHz clock
	always #50 clock_in = ~clock_in;
	// Hang guard, well above the roughly 650 cycles the run needs
	always @(posedge clock_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			failures++;
			summarize();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h8020_0003 : 32'h0);
	endfunction
	// Expected content after one edge; hardware is applied last so it wins a tie
	function automatic logic [31:0] nxt(input logic [31:0] v, wd, hm, hd, input logic w, hw);
		logic [31:0] n;
		n = v;
		if (w)
			n = ((n & ~RW_M) | (wd & RW_M)) & ~(CO_M & ~wd);
		if (hw)
			n = (n & ~hm) | (hd & hm);
		return n & ~RS_M;
	endfunction
	task automatic chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One access cycle, then an idle cycle so strobes are never taken twice
	task automatic op(input logic w, r, hw, input logic [31:0] wd, hm, hd);
		logic [31:0] pre;
		@(posedge clock_in);
		sw_wr_in <= w;
		sw_rd_in <= r;
		hw_wr_in <= hw;
		sw_wdata_in <= wd;
		hw_wmask_in <= hm;
		hw_wdata_in <= hd;
		@(posedge clock_in);
		sw_wr_in <= 1'b0;
		sw_rd_in <= 1'b0;
		hw_wr_in <= 1'b0;
		pre = exp_q;
		exp_q = nxt(exp_q, wd, hm, hd, w, hw);
		@(negedge clock_in);
		chk({31'h0, sw_rvalid_out}, {31'h0, r});
		if (r)
			chk(sw_rdata_out, pre);
		@(negedge clock_in);
		chk(hw_value_out, exp_q);
	endtask
	task automatic do_reset();
		@(posedge clock_in);
		rst_n_in <= 1'b0;
		repeat (9) @(posedge clock_in);
		// Look while reset still holds: defined bits known, straps not yet taken
		@(negedge clock_in);
		chk(hw_value_out, ZERO_WORD);
		chk(sw_rdata_out, ZERO_WORD);
		chk(ro_known_out, ~UNDEF_MASK_DEF & ~EXT_SET_MASK_DEF);
		@(posedge clock_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 20 && cfg_ready_out !== 1'b1; i++)
			@(negedge clock_in);
		chk({31'h0, cfg_ready_out}, 32'h1);
		chk(ro_known_out, ~UNDEF_MASK_DEF);
		exp_q = strap_in & EXT_SET_MASK_DEF;
		op(0, 1, 0, 32'h0, 32'h0, 32'h0);
		$display("test reset done");
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Main sequence: reset, corners, random traffic, a final reset
	initial
	begin
		do_reset();
		@(posedge clock_in);
		strap_in <= 32'h0000_5A5A;
		op(1, 1, 0, 32'hFFFF_FFFF, 32'h0, 32'h0);
		op(1, 1, 0, 32'h0, 32'h0, 32'h0);
		op(0, 1, 1, 32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
		op(1, 1, 1, 32'h0, 32'h0000_0F0F, 32'h0);
		op(1, 1, 0, 32'hFEFF_FF00, 32'h0, 32'h0);
		// Write back what the last read returned instead of assuming zeros
		op(1, 1, 0, sw_rdata_out, 32'h0, 32'h0);
		$display("test corners done");
		for (int i = 0; i < 200; i++)
		begin
			a = lfsr(rnd);
			b = lfsr(a);
			rnd = lfsr(b);
			op(a[0], a[1], a[2] & a[3], a, b, rnd);
		end
		$display("test random done");
		do_reset();
		summarize();
	end
endmodule // rfa_field_reg_tb
